// ===== core/psme_core.sv
// Status register, banked registers and exception entry behind an AXI4-Lite slave.
//
// Notes on behaviour
// RQ1 - Compact instruction set runs while the state bit is one.
// RQ2 - A status write never alters the instruction-set state bit.
// RQ3 - Mode codes: user, fast irq, irq, supervisor, abort, undefined, system.
// RQ4 - Fast irq banks r8-r14; other exception modes bank r13, r14 only.
// RQ5 - Privileged write of an illegal mode code selects system mode.
// RQ6 - User mode reads the mode field but its writes are dropped.
// RQ7 - Flags, sticky overflow, SIMD bits and endianness writable in any mode.
// RQ8 - Execution-state bits 26:24, 15:10 and 5 ignore status writes.
// RQ9 - Abort mask, interrupt masks and mode written only when privileged.
// RQ10 - Supervisor call and undefined entry link: address plus 4 or 2.
// RQ11 - Prefetch abort, breakpoint and interrupt entry link: address plus 4.
// RQ12 - Data abort entry link: address plus 8.
// RQ13 - Reset entry leaves the supervisor link register undefined.
// RQ14 - Entry saves current status into the target saved status; a supervisor call saves it with the block state advanced.
// RQ15 - Entry forces the target mode and clears conditional-block bits.
// RQ16 - Entry sets endianness from the exception endianness control bit.
// RQ17 - Entry sets the state bit from the exception state control bit.
// RQ18 - Entry finally redirects fetch to the exception vector.
// RQ19 - Entry sets interrupt masks to keep nesting manageable.
// RQ20 - Return restores state, endianness and mask bits from saved status.
// RQ21 - Reset gives supervisor mode with abort and both interrupt masks set.
// RQ22 - Target mode chosen by exception type.
module psme_core (
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // Write address channel.
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  // Write data channel.
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  // Write response channel.
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // Read address channel.
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  // Read data channel.
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Core state.
  output logic [31:0] cur_status_reg,
  output logic compact_isa,
  output logic fetch_redirect,
  output logic [31:0] fetch_vector
);

  ////////////////////////////////////////////////////////////////////////////
  // Storage.

  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic [31:0] faddr;
  logic [1:0] sysctl;
  logic [31:0] usr_hi [7];
  logic [31:0] fiq_hi [7];
  logic [31:0] bk_sp [4];
  logic [31:0] bk_lr [4];
  logic [31:0] saved_status_reg [5];

  ////////////////////////////////////////////////////////////////////////////
  // Decoding functions.

  function automatic logic addr_ok(input logic [7:0] a);
    logic ok;
    ok = 1'b0;
    if (a[1:0] == 2'h0 && a <= psme_pkg::OFS_RETURN) begin
      ok = 1'b1;
    end
    if (a[1:0] == 2'h0 && a[7:5] == psme_pkg::BANK_REGION && a[4:2] != 3'h7) begin
      ok = 1'b1;
    end
    return ok;
  endfunction

  function automatic logic is_bank(input logic [7:0] a);
    return a[1:0] == 2'h0 && a[7:5] == psme_pkg::BANK_REGION && a[4:2] != 3'h7;
  endfunction

  function automatic logic mode_ok(input logic [4:0] m);
    logic ok;
    ok = 1'b0;
    case (m) // RQ3
      psme_pkg::MODE_USR, psme_pkg::MODE_FIQ, psme_pkg::MODE_IRQ,
      psme_pkg::MODE_SVC, psme_pkg::MODE_ABT, psme_pkg::MODE_UND,
      psme_pkg::MODE_SYS: ok = 1'b1;
      default: ok = 1'b0;
    endcase
    return ok;
  endfunction

  function automatic logic [31:0] fix_mode(input logic [31:0] s);
    logic [31:0] r;
    r = s;
    if (!mode_ok(s[4:0])) begin
      r[4:0] = psme_pkg::MODE_SYS; // RQ5
    end
    return r;
  endfunction

  // User and system share the unbanked set, so both map to no bank.
  function automatic logic [2:0] bank_of(input logic [4:0] m);
    logic [2:0] b;
    case (m) // RQ4
      psme_pkg::MODE_FIQ: b = psme_pkg::BANK_FIQ;
      psme_pkg::MODE_IRQ: b = 3'h1;
      psme_pkg::MODE_SVC: b = 3'h2;
      psme_pkg::MODE_ABT: b = 3'h3;
      psme_pkg::MODE_UND: b = 3'h4;
      default: b = psme_pkg::BANK_NONE;
    endcase
    return b;
  endfunction

  function automatic logic [4:0] target_mode(input psme_pkg::psme_exc_t e);
    logic [4:0] m;
    unique case (e) // RQ22
      psme_pkg::EXC_FIQ: m = psme_pkg::MODE_FIQ;
      psme_pkg::EXC_IRQ: m = psme_pkg::MODE_IRQ;
      psme_pkg::EXC_PREFETCH_ABORT, psme_pkg::EXC_DATA_ABORT,
      psme_pkg::EXC_BREAKPOINT_INSTR: m = psme_pkg::MODE_ABT;
      psme_pkg::EXC_UND: m = psme_pkg::MODE_UND;
      psme_pkg::EXC_SVC, psme_pkg::EXC_RESET: m = psme_pkg::MODE_SVC;
    endcase
    return m;
  endfunction

  function automatic logic [31:0] vector_of(input psme_pkg::psme_exc_t e);
    logic [31:0] v;
    unique case (e)
      psme_pkg::EXC_RESET: v = psme_pkg::VEC_RESET;
      psme_pkg::EXC_UND: v = psme_pkg::VEC_UND;
      psme_pkg::EXC_SVC: v = psme_pkg::VEC_SVC;
      psme_pkg::EXC_PREFETCH_ABORT, psme_pkg::EXC_BREAKPOINT_INSTR: v = psme_pkg::VEC_PREFETCH_ABORT;
      psme_pkg::EXC_DATA_ABORT: v = psme_pkg::VEC_DATA_ABORT;
      psme_pkg::EXC_IRQ: v = psme_pkg::VEC_IRQ;
      psme_pkg::EXC_FIQ: v = psme_pkg::VEC_FIQ;
    endcase
    return psme_pkg::VEC_BASE + v;
  endfunction

  function automatic logic [31:0] link_ofs(input psme_pkg::psme_exc_t e, input logic t);
    logic [31:0] o;
    o = psme_pkg::LINK_WIDE; // RQ11
    if (e == psme_pkg::EXC_SVC || e == psme_pkg::EXC_UND) begin
      o = t ? psme_pkg::LINK_NARROW : psme_pkg::LINK_WIDE; // RQ10
    end
    if (e == psme_pkg::EXC_DATA_ABORT) begin
      o = psme_pkg::LINK_DATA_ABORT; // RQ12
    end
    return o;
  endfunction

  // Advancing the block state lets a supervisor call return past itself.
  function automatic logic [31:0] it_advance(input logic [31:0] s);
    logic [7:0] it;
    logic [31:0] r;
    it = {s[15:10], s[26:25]};
    if (it[2:0] == 3'h0) begin
      it = 8'h00;
    end else begin
      it[4:0] = {it[3:0], 1'b0};
    end
    r = s;
    r[15:10] = it[7:2];
    r[26:25] = it[1:0];
    return r;
  endfunction

  function automatic logic [31:0] entry_status(input logic [31:0] s,
      input psme_pkg::psme_exc_t e, input logic [1:0] ctl);
    logic [31:0] r;
    r = s & ~psme_pkg::MASK_IT; // RQ15
    r[4:0] = target_mode(e); // RQ15
    r[psme_pkg::BIT_E] = ctl[psme_pkg::SYSCTL_EE]; // RQ16
    r[psme_pkg::BIT_T] = ctl[psme_pkg::SYSCTL_TE]; // RQ17
    r[psme_pkg::BIT_I] = 1'b1; // RQ19
    if (e == psme_pkg::EXC_FIQ || e == psme_pkg::EXC_RESET) begin
      r[psme_pkg::BIT_F] = 1'b1; // RQ19
    end
    if (e != psme_pkg::EXC_UND && e != psme_pkg::EXC_SVC) begin
      r[psme_pkg::BIT_A] = 1'b1; // RQ19
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Write decode and next status.

  wire do_write = !awready && !wready && !bvalid;
  wire wr_cur = do_write && aw_addr == psme_pkg::OFS_CUR;
  wire wr_saved = do_write && aw_addr == psme_pkg::OFS_SAVED;
  wire wr_exc = do_write && aw_addr == psme_pkg::OFS_EXC;
  wire wr_faddr = do_write && aw_addr == psme_pkg::OFS_FADDR;
  wire wr_sysctl = do_write && aw_addr == psme_pkg::OFS_SYSCTL;
  wire wr_side = do_write && aw_addr == psme_pkg::OFS_SIDE;
  wire wr_ret = do_write && aw_addr == psme_pkg::OFS_RETURN;
  wire wr_bank = do_write && is_bank(aw_addr);
  wire [2:0] wn = aw_addr[4:2];
  wire [4:0] cur_mode = cur_status_reg[4:0];
  wire cur_priv = cur_mode != psme_pkg::MODE_USR;
  wire [2:0] cb = bank_of(cur_mode);
  wire [1:0] cb_x = 2'(cb - 3'h1);
  wire has_saved = cb != psme_pkg::BANK_NONE;
  wire [31:0] saved_cur = has_saved ? saved_status_reg[cb] : 32'h00000000;
  wire [31:0] byte_mask = {{8{w_strb[3]}}, {8{w_strb[2]}}, {8{w_strb[1]}}, {8{w_strb[0]}}};
  // A status write never reaches the execution-state bits or the state bit.
  wire [31:0] msr_mask = byte_mask & (psme_pkg::MASK_FREE | (cur_priv ? psme_pkg::MASK_PRIV : 32'h0)); // RQ2 RQ8
  wire [31:0] msr_val = fix_mode((cur_status_reg & ~msr_mask) | (w_data & msr_mask)); // RQ6 RQ7 RQ9
  wire [31:0] side_mask = byte_mask & (psme_pkg::MASK_FREE | psme_pkg::MASK_IT);
  wire [31:0] side_val = (cur_status_reg & ~side_mask) | (w_data & side_mask); // RQ7 RQ8
  wire psme_pkg::psme_exc_t exc = psme_pkg::psme_exc_t'(w_data[2:0]);
  wire [2:0] tb = bank_of(target_mode(exc));
  wire [1:0] tb_x = 2'(tb - 3'h1);
  wire [31:0] save_val = (exc == psme_pkg::EXC_SVC) ? it_advance(cur_status_reg) : cur_status_reg; // RQ14
  wire [31:0] entry_val = entry_status(cur_status_reg, exc, sysctl);
  wire [31:0] lr_val = faddr + link_ofs(exc, cur_status_reg[psme_pkg::BIT_T]);
  wire [31:0] ret_val = fix_mode(saved_cur & psme_pkg::MASK_IMPL); // RQ20
  wire [31:0] next_cur = wr_cur ? msr_val :
                         wr_side ? side_val :
                         wr_exc ? entry_val :
                         (wr_ret && has_saved) ? ret_val : cur_status_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Write channel.

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready <= 1'b1;
      wready <= 1'b1;
    end else begin
      if (awvalid && awready) begin
        awready <= 1'b0;
      end else if (bvalid && bready) begin
        awready <= 1'b1;
      end
      if (wvalid && wready) begin
        wready <= 1'b0;
      end else if (bvalid && bready) begin
        wready <= 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (awvalid && awready) begin
      aw_addr <= awaddr;
    end
    if (wvalid && wready) begin
      w_data <= wdata;
      w_strb <= wstrb;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp <= psme_pkg::RESP_OKAY;
    end else if (do_write) begin
      bvalid <= 1'b1;
      bresp <= addr_ok(aw_addr) ? psme_pkg::RESP_OKAY : psme_pkg::RESP_SLVERR;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status, control and fetch redirect.

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cur_status_reg <= psme_pkg::CUR_RESET; // RQ21
      compact_isa <= 1'b0;
      faddr <= 32'h00000000;
      sysctl <= 2'h0;
      fetch_redirect <= 1'b0;
      fetch_vector <= psme_pkg::VEC_BASE;
    end else begin
      cur_status_reg <= next_cur;
      compact_isa <= next_cur[psme_pkg::BIT_T]; // RQ1
      fetch_redirect <= wr_exc; // RQ18
      if (wr_exc) begin
        fetch_vector <= vector_of(exc); // RQ18
      end
      if (wr_faddr) begin
        faddr <= w_data;
      end
      if (wr_sysctl) begin
        sysctl <= w_data[1:0];
      end
    end
  end

  // Banked registers hold data only, so they carry no reset.
  always_ff @(posedge aclk) begin
    if (wr_saved && has_saved) begin
      saved_status_reg[cb] <= w_data & psme_pkg::MASK_IMPL;
    end
    if (wr_exc) begin
      saved_status_reg[tb] <= save_val; // RQ14
    end
    if (wr_exc && exc != psme_pkg::EXC_RESET) begin // RQ13
      if (tb == psme_pkg::BANK_FIQ) begin
        fiq_hi[psme_pkg::BANK_LR_IDX] <= lr_val; // RQ10 RQ11 RQ12
      end else begin
        bk_lr[tb_x] <= lr_val; // RQ10 RQ11 RQ12
      end
    end
    if (wr_bank) begin
      if (cb == psme_pkg::BANK_FIQ) begin
        fiq_hi[wn] <= w_data; // RQ4
      end else if (has_saved && wn == psme_pkg::BANK_SP_IDX) begin
        bk_sp[cb_x] <= w_data; // RQ4
      end else if (has_saved && wn == psme_pkg::BANK_LR_IDX) begin
        bk_lr[cb_x] <= w_data; // RQ4
      end else begin
        usr_hi[wn] <= w_data; // RQ4
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read channel.

  // The banked arrays are read here, not in a function, so the read value follows every array update.
  wire [31:0] bank_word = (cb == psme_pkg::BANK_FIQ) ? fiq_hi[araddr[4:2]] : // RQ4
                          (has_saved && araddr[4:2] == psme_pkg::BANK_SP_IDX) ? bk_sp[cb_x] :
                          (has_saved && araddr[4:2] == psme_pkg::BANK_LR_IDX) ? bk_lr[cb_x] :
                          usr_hi[araddr[4:2]];
  wire [31:0] rd_value = !addr_ok(araddr) ? 32'h00000000 :
                         is_bank(araddr) ? bank_word :
                         araddr == psme_pkg::OFS_CUR ? cur_status_reg : // RQ6
                         araddr == psme_pkg::OFS_SAVED ? saved_cur :
                         araddr == psme_pkg::OFS_FADDR ? faddr :
                         araddr == psme_pkg::OFS_SYSCTL ? {30'h00000000, sysctl} :
                         araddr == psme_pkg::OFS_VECTOR ? fetch_vector : 32'h00000000;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= 32'h00000000;
      rresp <= psme_pkg::RESP_OKAY;
    end else if (arvalid && arready) begin
      arready <= 1'b0;
      rvalid <= 1'b1;
      rdata <= rd_value;
      rresp <= addr_ok(araddr) ? psme_pkg::RESP_OKAY : psme_pkg::RESP_SLVERR;
    end else if (rvalid && rready) begin
      arready <= 1'b1;
      rvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  chk_state_bit_kept: assert property (@(posedge aclk) disable iff (!aresetn) // RQ2
    wr_cur |=> cur_status_reg[5] == $past(cur_status_reg[5]) && compact_isa == cur_status_reg[5])
    else $error("status write changed the state bit");

  chk_exec_bits_kept: assert property (@(posedge aclk) disable iff (!aresetn) // RQ8
    wr_cur |=> cur_status_reg[26:24] == $past(cur_status_reg[26:24])
      && cur_status_reg[15:10] == $past(cur_status_reg[15:10]))
    else $error("status write changed execution-state bits");

  chk_user_priv_kept: assert property (@(posedge aclk) disable iff (!aresetn) // RQ9
    wr_cur && !cur_priv |=> cur_status_reg[8:6] == $past(cur_status_reg[8:6])
      && cur_mode == psme_pkg::MODE_USR)
    else $error("user status write changed masks or mode");

  chk_illegal_to_sys: assert property (@(posedge aclk) disable iff (!aresetn) // RQ5
    wr_cur && cur_priv && w_strb[0] && !mode_ok(w_data[4:0]) |=> cur_mode == psme_pkg::MODE_SYS)
    else $error("illegal mode code did not select system mode");

  chk_free_flags: assert property (@(posedge aclk) disable iff (!aresetn) // RQ7
    wr_cur && w_strb[3] |=> cur_status_reg[31:27] == $past(w_data[31:27]))
    else $error("flag write not taken");

  chk_entry_mode: assert property (@(posedge aclk) disable iff (!aresetn) // RQ15
    wr_exc |=> cur_mode == $past(target_mode(exc)) && (cur_status_reg & psme_pkg::MASK_IT) == 32'h0)
    else $error("entry mode or block state wrong");

  chk_entry_ctl: assert property (@(posedge aclk) disable iff (!aresetn) // RQ16
    wr_exc |=> cur_status_reg[9] == $past(sysctl[0]) && cur_status_reg[5] == $past(sysctl[1])
      && cur_status_reg[7])
    else $error("entry endianness, state or mask wrong");

  chk_entry_vector: assert property (@(posedge aclk) disable iff (!aresetn) // RQ18
    wr_exc |=> fetch_redirect && fetch_vector == $past(vector_of(exc)) ##1 !fetch_redirect)
    else $error("fetch redirect wrong");

  chk_entry_save: assert property (@(posedge aclk) disable iff (!aresetn) // RQ14
    wr_exc |=> saved_status_reg[$past(tb)] == $past(save_val))
    else $error("status not saved on entry");

  chk_svc_link: assert property (@(posedge aclk) disable iff (!aresetn) // RQ10
    wr_exc && exc == psme_pkg::EXC_SVC |=>
      bk_lr[1] == $past(faddr) + ($past(cur_status_reg[5]) ? 32'h2 : 32'h4))
    else $error("supervisor link value wrong");

  chk_data_abort_link: assert property (@(posedge aclk) disable iff (!aresetn) // RQ12
    wr_exc && exc == psme_pkg::EXC_DATA_ABORT |=> bk_lr[2] == $past(faddr) + 32'h8)
    else $error("data abort link value wrong");

  chk_return_restore: assert property (@(posedge aclk) disable iff (!aresetn) // RQ20
    wr_ret && has_saved |=> cur_status_reg[9:5] == $past(saved_cur[9:5]))
    else $error("return did not restore state bits");

  chk_reset_state: assert property (@(posedge aclk) // RQ21
    !aresetn |=> cur_mode == psme_pkg::MODE_SVC && cur_status_reg[8:6] == 3'h7)
    else $error("reset status wrong");

endmodule

// ===== core/psme_pkg.sv
// Constants and types for the status register and exception entry block.
package psme_pkg;
  // Register byte offsets on the bus.
  localparam logic [7:0] OFS_CUR = 8'h00;
  localparam logic [7:0] OFS_SAVED = 8'h04;
  localparam logic [7:0] OFS_EXC = 8'h08;
  localparam logic [7:0] OFS_FADDR = 8'h0c;
  localparam logic [7:0] OFS_SYSCTL = 8'h10;
  localparam logic [7:0] OFS_VECTOR = 8'h14;
  localparam logic [7:0] OFS_SIDE = 8'h18;
  localparam logic [7:0] OFS_RETURN = 8'h1c;
  localparam logic [2:0] BANK_REGION = 3'h2;
  localparam logic [2:0] BANK_SP_IDX = 3'h5;
  localparam logic [2:0] BANK_LR_IDX = 3'h6;
  // Mode field codes.
  localparam logic [4:0] MODE_USR = 5'h10;
  localparam logic [4:0] MODE_FIQ = 5'h11;
  localparam logic [4:0] MODE_IRQ = 5'h12;
  localparam logic [4:0] MODE_SVC = 5'h13;
  localparam logic [4:0] MODE_ABT = 5'h17;
  localparam logic [4:0] MODE_UND = 5'h1b;
  localparam logic [4:0] MODE_SYS = 5'h1f;
  // Saved status bank numbers.
  localparam logic [2:0] BANK_FIQ = 3'h0;
  localparam logic [2:0] BANK_NONE = 3'h7;
  // Status bit positions and field masks.
  localparam int BIT_T = 5;
  localparam int BIT_F = 6;
  localparam int BIT_I = 7;
  localparam int BIT_A = 8;
  localparam int BIT_E = 9;
  localparam logic [31:0] MASK_FREE = 32'hf80f0200;
  localparam logic [31:0] MASK_PRIV = 32'h000001df;
  localparam logic [31:0] MASK_IT = 32'h0600fc00;
  localparam logic [31:0] MASK_IMPL = 32'hfe0fffff;
  localparam logic [31:0] CUR_RESET = 32'h000001d3;
  // System control bits.
  localparam int SYSCTL_EE = 0;
  localparam int SYSCTL_TE = 1;
  // Link offsets and vectors.
  localparam logic [31:0] LINK_NARROW = 32'h00000002;
  localparam logic [31:0] LINK_WIDE = 32'h00000004;
  localparam logic [31:0] LINK_DATA_ABORT = 32'h00000008;
  localparam logic [31:0] VEC_BASE = 32'h00000000;
  localparam logic [31:0] VEC_RESET = 32'h00000000;
  localparam logic [31:0] VEC_UND = 32'h00000004;
  localparam logic [31:0] VEC_SVC = 32'h00000008;
  localparam logic [31:0] VEC_PREFETCH_ABORT = 32'h0000000c;
  localparam logic [31:0] VEC_DATA_ABORT = 32'h00000010;
  localparam logic [31:0] VEC_IRQ = 32'h00000018;
  localparam logic [31:0] VEC_FIQ = 32'h0000001c;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [2:0] {
    EXC_RESET = 3'h0, EXC_UND = 3'h1, EXC_SVC = 3'h2, EXC_PREFETCH_ABORT = 3'h3,
    EXC_DATA_ABORT = 3'h4, EXC_BREAKPOINT_INSTR = 3'h5, EXC_IRQ = 3'h6, EXC_FIQ = 3'h7
  } psme_exc_t;
endpackage

// ===== verification/psme_core_tb.sv
// Self-checking bench for the status register and exception entry block.
module psme_core_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic awvalid = 1'b0;
  logic awready;
  logic [31:0] wdata = 32'h00000000;
  logic [3:0] wstrb = 4'h0;
  logic wvalid = 1'b0;
  logic wready;
  logic [1:0] bresp;
  logic bvalid;
  logic bready = 1'b0;
  logic [7:0] araddr = 8'h00;
  logic arvalid = 1'b0;
  logic arready;
  logic [31:0] rdata;
  logic [1:0] rresp;
  logic rvalid;
  logic rready = 1'b0;
  logic [31:0] cur_status_reg;
  logic compact_isa;
  logic fetch_redirect;
  logic [31:0] fetch_vector;
  int fails = 0;
  int num_checks = 0;
  int redirs = 0;
  logic [31:0] exp_cur;
  logic [31:0] sav;
  logic [31:0] rd;
  logic [1:0] rsp;

  psme_core psme_core_inst (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .cur_status_reg(cur_status_reg),
    .compact_isa(compact_isa), .fetch_redirect(fetch_redirect), .fetch_vector(fetch_vector));

  always #5 aclk = ~aclk;

  // Counting pulses rather than sampling one edge keeps the check free of latency guesses.
  always @(posedge aclk) if (fetch_redirect === 1'b1) redirs++;

  ////////////////////////////////////////////////////////////////////////////
  task automatic finish_test;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  // Address and data are offered together; each is dropped at the edge that takes it.
  task automatic bus_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw_ok;
    logic w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wstrb <= 4'hf;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      if (!aw_ok && awready === 1'b1) begin
        aw_ok = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w_ok && wready === 1'b1) begin
        w_ok = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
  endtask

  task automatic bus_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ar_ok;
    ar_ok = 1'b0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (!ar_ok && arready === 1'b1) begin
        ar_ok = 1'b1;
        arvalid <= 1'b0;
      end
    end while (!(ar_ok && rvalid === 1'b1));
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus_write(a, d, rsp);
    check({30'h0, rsp}, {30'h0, psme_pkg::RESP_OKAY}, "write response");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    check(cur_status_reg, 32'h000001d3, "status after reset");
    check({31'h0, compact_isa}, 32'h0, "state bit after reset");
    check(fetch_vector, 32'h0, "vector after reset");
    $display("test reset done");
  endtask

  // Supervisor writes all ones, then system mode writes an illegal mode code.
  task automatic t_priv_write;
    wr(psme_pkg::OFS_CUR, 32'hffffffff);
    check(cur_status_reg, 32'hf80f03df, "privileged status write");
    wr(psme_pkg::OFS_CUR, 32'h000001d5);
    check(cur_status_reg, 32'h000001df, "illegal mode code");
    $display("test privileged write done");
  endtask

  // User mode may change only the free bits, and has no saved status.
  task automatic t_user_write;
    wr(psme_pkg::OFS_CUR, 32'h00000010);
    wr(psme_pkg::OFS_CUR, 32'hf80f03df);
    exp_cur = 32'hf80f0210;
    check(cur_status_reg, exp_cur, "user status write");
    bus_read(psme_pkg::OFS_CUR, rd, rsp);
    check(rd, exp_cur, "user status read");
    bus_read(psme_pkg::OFS_SAVED, rd, rsp);
    check(rd, 32'h0, "user saved status");
    $display("test user write done");
  endtask

  // Chained entries of every type; control bits vary so both link offsets appear.
  task automatic t_entries;
    logic [31:0] vecs [8];
    logic [31:0] prev;
    logic [31:0] e;
    logic [31:0] lnk;
    logic [2:0] ty;
    logic [1:0] ctl;
    int base;
    vecs = '{32'h0, 32'h4, 32'h8, 32'hc, 32'h10, 32'hc, 32'h18, 32'h1c};
    for (int i = 0; i < 8; i++) begin
      ty = 3'(i + 1);
      ctl = 2'(3 - i);
      prev = exp_cur;
      base = redirs;
      e = prev & 32'hf80f01c0;
      e[9] = ctl[0];
      e[5] = ctl[1];
      e[7] = 1'b1;
      e[8] = (ty == 3'h1 || ty == 3'h2) ? prev[8] : 1'b1;
      e[6] = (ty == 3'h0 || ty == 3'h7) ? 1'b1 : prev[6];
      e[4:0] = (ty == 3'h0 || ty == 3'h2) ? 5'h13 : ty == 3'h1 ? 5'h1b : ty == 3'h6 ? 5'h12 :
        ty == 3'h7 ? 5'h11 : 5'h17;
      lnk = ty == 3'h4 ? 32'h108 : ((ty == 3'h1 || ty == 3'h2) && prev[5]) ? 32'h102 : 32'h104;
      wr(psme_pkg::OFS_SYSCTL, {30'h0, ctl});
      wr(psme_pkg::OFS_FADDR, 32'h00000100);
      wr(psme_pkg::OFS_EXC, {29'h0, ty});
      check(cur_status_reg, e, "status after entry");
      check({31'h0, compact_isa}, {31'h0, ctl[1]}, "instruction set select");
      check(fetch_vector, vecs[ty], "entry vector");
      bus_read(psme_pkg::OFS_SAVED, rd, rsp);
      check(rd, prev, "saved status");
      bus_read(8'h58, rd, rsp);
      if (ty != 3'h0) check(rd, lnk, "link value");
      check(32'(redirs - base), 32'h1, "redirect pulses");
      sav = prev;
      exp_cur = e;
    end
    $display("test entries done");
  endtask

  task automatic t_return;
    wr(psme_pkg::OFS_RETURN, 32'h0);
    check(cur_status_reg, sav, "status after return");
    $display("test return done");
  endtask

  // Fast irq mode sees its own r8; system mode must not overwrite it.
  task automatic t_bank;
    wr(8'h40, 32'ha5a5a5a5);
    wr(psme_pkg::OFS_CUR, 32'h000001df);
    wr(8'h40, 32'h11111111);
    wr(psme_pkg::OFS_CUR, 32'h000001d1);
    bus_read(8'h40, rd, rsp);
    check(rd, 32'ha5a5a5a5, "banked r8");
    $display("test bank done");
  endtask

  // Side effects reach the block state; a supervisor call then saves it advanced.
  task automatic t_side;
    wr(psme_pkg::OFS_SIDE, 32'hffffffff);
    check(cur_status_reg, 32'hfe0fffd1, "side effect write");
    wr(psme_pkg::OFS_EXC, 32'h00000002);
    check(cur_status_reg, 32'hf80f01d3, "supervisor entry");
    bus_read(psme_pkg::OFS_SAVED, rd, rsp);
    check(rd, 32'hfc0fffd1, "advanced saved status");
    bus_read(psme_pkg::OFS_VECTOR, rd, rsp);
    check(rd, 32'h00000008, "vector read");
    wr(psme_pkg::OFS_SAVED, 32'hffffffff);
    bus_read(psme_pkg::OFS_SAVED, rd, rsp);
    check(rd, 32'hfe0fffff, "saved status write");
    $display("test side done");
  endtask

  task automatic t_unmapped;
    bus_write(8'h30, 32'hffffffff, rsp);
    check({30'h0, rsp}, {30'h0, psme_pkg::RESP_SLVERR}, "unmapped write");
    bus_read(8'h02, rd, rsp);
    check({30'h0, rsp}, {30'h0, psme_pkg::RESP_SLVERR}, "unaligned read");
    check(rd, 32'h0, "unaligned read data");
    $display("test unmapped done");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    #20000;
    fails++;
    finish_test();
  end

  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset();
    t_priv_write();
    t_user_write();
    t_entries();
    t_return();
    t_bank();
    t_side();
    t_unmapped();
    finish_test();
  end
endmodule
